// ==== inc/cdg_pkg.sv ====
package cdg_pkg;

	localparam int          ADDR_W         = 28;
	localparam int          DATA_W         = 32;
	localparam int          SRC_N          = 8;

	// register byte addresses
	localparam logic [27:0] OFF_CORE_SEL   = 28'hFFFE000;
	localparam logic [27:0] OFF_ASYNC_SEL  = 28'hFFFE004;
	localparam logic [27:0] OFF_RT_SEL     = 28'hFFFE008;
	localparam logic [27:0] OFF_DISABLE    = 28'hFFFE00C;
	localparam logic [27:0] OFF_PERIPH_DIV = 28'hFFFE010;
	localparam logic [27:0] OFF_SLIP_CFG   = 28'hFFFE014;
	localparam logic [27:0] OFF_STATUS     = 28'hFFFE018;
	localparam logic [27:0] OFF_MASK       = 28'hFFFE01C;
	localparam logic [27:0] OFF_SRC_EN     = 28'hFFFE020;
	localparam logic [27:0] OFF_ST_DIV     = 28'hFFFE108;

	// source numbers
	localparam logic [2:0]  SRC_OSC        = 3'h0;
	localparam logic [3:0]  ASRC_PERIPH    = 4'h9;

	// reset values
	localparam logic [7:0]  SRC_EN_RST     = 8'h31;
	localparam logic [9:0]  DISABLE_RST    = 10'h000;

	// disable bits
	localparam int          DIS_CPU        = 0;
	localparam int          DIS_SYS        = 1;
	localparam int          DIS_PER1       = 2;
	localparam int          DIS_PER2       = 3;
	localparam int          DIS_ASYNC      = 4;
	localparam int          DIS_RT         = 6;
	localparam int          DIS_PER4       = 9;

	// field positions
	localparam int          RT_DIV_LSB     = 8;
	localparam int          PDIV_PER2_LSB  = 2;
	localparam int          PDIV_PER4_LSB  = 4;

	// peripheral divide codes
	localparam logic [1:0]  PDIV_1         = 2'h0;
	localparam logic [1:0]  PDIV_2         = 2'h1;
	localparam logic [1:0]  PDIV_16        = 2'h2;
	localparam logic [4:0]  RATIO_1        = 5'h01;
	localparam logic [4:0]  RATIO_2        = 5'h02;
	localparam logic [4:0]  RATIO_16       = 5'h10;

	// status bits
	localparam int          STS_SLIP       = 0;
	localparam int          STS_SWITCH     = 1;

	typedef enum logic [1:0] {
		SW_RUN  = 2'b01,
		SW_WAIT = 2'b10
	} cdg_sw_t;

endpackage

// ==== logic/cdg_tick_div.sv ====
`timescale 1ns/10ps
module cdg_tick_div
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       inTick,
	input  wire logic [4:0] ratio,
	input  wire logic       enable,
	output logic            outTick
);

	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [4:0] ratio_r;
	logic [4:0] ratio_nxt;
	logic       en_r;
	logic       en_nxt;
	logic       tick_r;
	logic       tick_nxt;

	////////////////////////////////////////////////////////////////////////
	// boundary-only update
	// ratio and gate are only taken at a period wrap, so no short pulse
	always_comb
	begin
		cnt_nxt   = cnt_r;
		ratio_nxt = ratio_r;
		en_nxt    = en_r;
		tick_nxt  = 1'b0;
		if (inTick)
		begin
			if (cnt_r == 5'h00)
				tick_nxt = en_r;
			if (cnt_r + 5'h01 >= ratio_r)
			begin
				cnt_nxt   = 5'h00;
				ratio_nxt = (ratio == 5'h00) ? 5'h01 : ratio;
				en_nxt    = enable;
			end
			else
				cnt_nxt = cnt_r + 5'h01;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_r   <= 5'h00;
			ratio_r <= 5'h01;
			en_r    <= 1'b1;
			tick_r  <= 1'b0;
		end
		else
		begin
			cnt_r   <= cnt_nxt;
			ratio_r <= ratio_nxt;
			en_r    <= en_nxt;
			tick_r  <= tick_nxt;
		end
	end

	assign outTick = tick_r;

endmodule

// ==== logic/cdg_clock_domain_generator.sv ====
`timescale 1ns/10ps
module cdg_clock_domain_generator
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [27:0] addr,
	input  wire logic [31:0] wrData,
	input  wire logic        wrStrobe,
	input  wire logic        rdStrobe,
	output logic      [31:0] rdData,
	input  wire logic        main_osc_input,
	input  wire logic        pllClock,
	input  wire logic        external_clock_input1,
	input  wire logic        external_clock_input2,
	input  wire logic        lfLpoClock,
	input  wire logic        hfLpoClock,
	input  wire logic        pllSlip,
	input  wire logic        cpu_logic_selftest,
	output logic             systemBusTick,
	output logic             cpu_clock,
	output logic             cpu_clock_delayed,
	output logic             selftestTick,
	output logic             periph_clock_primary,
	output logic             periph_clock_secondary,
	output logic             periph_clock_fourth,
	output logic             async_periph_clock,
	output logic             realtime_irq_clock,
	output logic             deviceResetReq,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [2:0]  coreSel_r;
	logic [2:0]  coreSel_nxt;
	logic [3:0]  asyncSel_r;
	logic [3:0]  asyncSel_nxt;
	logic [3:0]  rtSel_r;
	logic [3:0]  rtSel_nxt;
	logic [1:0]  rtDiv_r;
	logic [1:0]  rtDiv_nxt;
	logic [9:0]  disable_r;
	logic [9:0]  disable_nxt;
	logic [5:0]  pDiv_r;
	logic [5:0]  pDiv_nxt;
	logic        slipRstEn_r;
	logic        slipRstEn_nxt;
	logic [1:0]  status_r;
	logic [1:0]  status_nxt;
	logic [1:0]  mask_r;
	logic [1:0]  mask_nxt;
	logic [7:0]  srcEn_r;
	logic [7:0]  srcEn_nxt;
	logic [2:0]  stDiv_r;
	logic [2:0]  stDiv_nxt;
	logic [31:0] rd_r;
	logic [31:0] rd_nxt;
	logic        slipEvt;
	logic        switchEvt;

	always_comb
	begin
		coreSel_nxt   = coreSel_r;
		asyncSel_nxt  = asyncSel_r;
		rtSel_nxt     = rtSel_r;
		rtDiv_nxt     = rtDiv_r;
		disable_nxt   = disable_r;
		pDiv_nxt      = pDiv_r;
		slipRstEn_nxt = slipRstEn_r;
		mask_nxt      = mask_r;
		srcEn_nxt     = srcEn_r;
		stDiv_nxt     = stDiv_r;
		status_nxt    = status_r;
		rd_nxt        = 32'h00000000;
		if (wrStrobe)
		begin
			case (addr)
				cdg_pkg::OFF_CORE_SEL:   coreSel_nxt = wrData[2:0];
				cdg_pkg::OFF_ASYNC_SEL:  asyncSel_nxt = wrData[3:0];
				cdg_pkg::OFF_RT_SEL:
				begin
					rtSel_nxt = wrData[3:0];
					rtDiv_nxt = wrData[cdg_pkg::RT_DIV_LSB +: 2];
				end
				cdg_pkg::OFF_DISABLE:    disable_nxt = wrData[9:0];
				cdg_pkg::OFF_PERIPH_DIV: pDiv_nxt = wrData[5:0];
				cdg_pkg::OFF_SLIP_CFG:   slipRstEn_nxt = wrData[0];
				cdg_pkg::OFF_MASK:       mask_nxt = wrData[1:0];
				cdg_pkg::OFF_SRC_EN:     srcEn_nxt = wrData[7:0];
				cdg_pkg::OFF_ST_DIV:     stDiv_nxt = wrData[2:0];
				default:                 ;
			endcase
		end
		if (rdStrobe)
		begin
			case (addr)
				cdg_pkg::OFF_CORE_SEL:   rd_nxt = {29'h0, coreSel_r};
				cdg_pkg::OFF_ASYNC_SEL:  rd_nxt = {28'h0, asyncSel_r};
				cdg_pkg::OFF_RT_SEL:
					rd_nxt = {22'h0, rtDiv_r, 4'h0, rtSel_r};
				cdg_pkg::OFF_DISABLE:    rd_nxt = {22'h0, disable_r};
				cdg_pkg::OFF_PERIPH_DIV: rd_nxt = {26'h0, pDiv_r};
				cdg_pkg::OFF_SLIP_CFG:   rd_nxt = {31'h0, slipRstEn_r};
				cdg_pkg::OFF_STATUS:
				begin
					rd_nxt     = {30'h0, status_r};
					status_nxt = 2'h0;
				end
				cdg_pkg::OFF_MASK:       rd_nxt = {30'h0, mask_r};
				cdg_pkg::OFF_SRC_EN:     rd_nxt = {24'h0, srcEn_r};
				cdg_pkg::OFF_ST_DIV:     rd_nxt = {29'h0, stDiv_r};
				default:                 rd_nxt = 32'h00000000;
			endcase
		end
		// a new event beats a clearing read in the same cycle
		if (slipEvt)
			status_nxt[cdg_pkg::STS_SLIP] = 1'b1;
		if (switchEvt)
			status_nxt[cdg_pkg::STS_SWITCH] = 1'b1;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			coreSel_r   <= cdg_pkg::SRC_OSC;
			asyncSel_r  <= cdg_pkg::ASRC_PERIPH;
			rtSel_r     <= cdg_pkg::ASRC_PERIPH;
			rtDiv_r     <= 2'h0;
			disable_r   <= cdg_pkg::DISABLE_RST;
			pDiv_r      <= 6'h00;
			slipRstEn_r <= 1'b0;
			mask_r      <= 2'h0;
			srcEn_r     <= cdg_pkg::SRC_EN_RST;
			stDiv_r     <= 3'h0;
			status_r    <= 2'h0;
			rd_r        <= 32'h00000000;
		end
		else
		begin
			coreSel_r   <= coreSel_nxt;
			asyncSel_r  <= asyncSel_nxt;
			rtSel_r     <= rtSel_nxt;
			rtDiv_r     <= rtDiv_nxt;
			disable_r   <= disable_nxt;
			pDiv_r      <= pDiv_nxt;
			slipRstEn_r <= slipRstEn_nxt;
			mask_r      <= mask_nxt;
			srcEn_r     <= srcEn_nxt;
			stDiv_r     <= stDiv_nxt;
			status_r    <= status_nxt;
			rd_r        <= rd_nxt;
		end
	end

	assign rdData = rd_r;
	assign irq    = |(status_r & mask_r);

	////////////////////////////////////////////////////////////////////////
	// source synchronisers and edge detect
	logic [7:0] srcPins;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] sync3_r;
	logic [7:0] srcRise;
	logic       slip1_r;
	logic       slip2_r;
	logic       slip3_r;

	// reserved sources 2 and 6 never tick
	assign srcPins = {external_clock_input2, 1'b0, hfLpoClock, lfLpoClock,
		external_clock_input1, 1'b0, pllClock, main_osc_input};

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			sync3_r <= 8'h00;
			slip1_r <= 1'b0;
			slip2_r <= 1'b0;
			slip3_r <= 1'b0;
		end
		else
		begin
			sync1_r <= srcPins;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			slip1_r <= pllSlip;
			slip2_r <= slip1_r;
			slip3_r <= slip2_r;
		end
	end

	// no validity check
	// an enabled source counts as good; only its enable bit gates it
	assign srcRise = sync2_r & ~sync3_r & srcEn_r;
	assign slipEvt = slip2_r & ~slip3_r;

	////////////////////////////////////////////////////////////////////////
	// glitch-free core switch
	// the old source finishes its period before the new one takes over
	cdg_pkg::cdg_sw_t swState_r;
	cdg_pkg::cdg_sw_t swState_nxt;
	logic [2:0]       curSel_r;
	logic [2:0]       curSel_nxt;
	logic             baseTick;

	always_comb
	begin
		swState_nxt = swState_r;
		curSel_nxt  = curSel_r;
		switchEvt   = 1'b0;
		case (swState_r)
			cdg_pkg::SW_RUN:
				if (coreSel_r != curSel_r)
					swState_nxt = cdg_pkg::SW_WAIT;
			cdg_pkg::SW_WAIT:
				// a disabled old source must not hang the switch
				if (srcRise[curSel_r] || !srcEn_r[curSel_r])
				begin
					curSel_nxt  = coreSel_r;
					swState_nxt = cdg_pkg::SW_RUN;
					switchEvt   = 1'b1;
				end
			default:
				swState_nxt = cdg_pkg::SW_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			swState_r <= cdg_pkg::SW_RUN;
			curSel_r  <= cdg_pkg::SRC_OSC;
		end
		else
		begin
			swState_r <= swState_nxt;
			curSel_r  <= curSel_nxt;
		end
	end

	assign baseTick = srcRise[curSel_r] && (swState_r == cdg_pkg::SW_RUN);

	////////////////////////////////////////////////////////////////////////
	// ratio decode
	function automatic logic [4:0] pRatio(input logic [1:0] code);
		case (code)
			cdg_pkg::PDIV_2:  pRatio = cdg_pkg::RATIO_2;
			cdg_pkg::PDIV_16: pRatio = cdg_pkg::RATIO_16;
			default:          pRatio = cdg_pkg::RATIO_1;
		endcase
	endfunction

	logic [4:0] cpuRatio;
	logic [4:0] stRatio;
	logic [4:0] rtRatio;
	logic       cpuTick;
	logic       per1Tick;
	logic       asyncBase;
	logic       rtBase;
	logic [1:0] dlySh_r;
	logic [1:0] dlySh_nxt;
	logic       dly_r;
	logic       dly_nxt;

	assign cpuRatio = cpu_logic_selftest ? {2'h0, stDiv_r} + 5'h01
		: cdg_pkg::RATIO_1;
	assign stRatio = cdg_pkg::RATIO_2;
	assign rtRatio = 5'(5'h01 << rtDiv_r);

	// one bus tick for all modules
	cdg_tick_div u_sys
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (baseTick),
		.ratio   (cdg_pkg::RATIO_1),
		.enable  (!disable_r[cdg_pkg::DIS_SYS]),
		.outTick (systemBusTick)
	);

	cdg_tick_div u_cpu
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (baseTick),
		.ratio   (cpuRatio),
		.enable  (!disable_r[cdg_pkg::DIS_CPU]),
		.outTick (cpuTick)
	);

	assign cpu_clock = cpuTick;

	// two-cycle lag
	// same divided stream shifted by two bus periods, so gate and divide follow
	always_comb
	begin
		dlySh_nxt = dlySh_r;
		dly_nxt   = 1'b0;
		if (baseTick)
		begin
			dlySh_nxt = {dlySh_r[0], 1'b0};
			dly_nxt   = dlySh_r[1];
		end
		if (cpuTick)
			dlySh_nxt[0] = 1'b1;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			dlySh_r <= 2'h0;
			dly_r   <= 1'b0;
		end
		else
		begin
			dlySh_r <= dlySh_nxt;
			dly_r   <= dly_nxt;
		end
	end

	assign cpu_clock_delayed = dly_r;

	cdg_tick_div u_stc
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (cpuTick),
		.ratio   (stRatio),
		.enable  (cpu_logic_selftest),
		.outTick (selftestTick)
	);

	// divide by 1, 2 or 16
	cdg_tick_div u_per1
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (baseTick),
		.ratio   (pRatio(pDiv_r[1:0])),
		.enable  (!disable_r[cdg_pkg::DIS_PER1]),
		.outTick (per1Tick)
	);

	assign periph_clock_primary = per1Tick;

	// secondary ratio relation is left to software
	cdg_tick_div u_per2
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (baseTick),
		.ratio   (pRatio(pDiv_r[cdg_pkg::PDIV_PER2_LSB +: 2])),
		.enable  (!disable_r[cdg_pkg::DIS_PER2]),
		.outTick (periph_clock_secondary)
	);

	cdg_tick_div u_per4
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (baseTick),
		.ratio   (pRatio(pDiv_r[cdg_pkg::PDIV_PER4_LSB +: 2])),
		.enable  (!disable_r[cdg_pkg::DIS_PER4]),
		.outTick (periph_clock_fourth)
	);

	// async source select
	// selecting a source number above 7 other than primary gives no clock
	assign asyncBase = (asyncSel_r == cdg_pkg::ASRC_PERIPH) ? per1Tick
		: (!asyncSel_r[3] && srcRise[asyncSel_r[2:0]]);

	cdg_tick_div u_async
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (asyncBase),
		.ratio   (cdg_pkg::RATIO_1),
		.enable  (!disable_r[cdg_pkg::DIS_ASYNC]),
		.outTick (async_periph_clock)
	);

	// realtime select, divide, gate
	// source rate limit is left to software
	assign rtBase = (rtSel_r == cdg_pkg::ASRC_PERIPH) ? per1Tick
		: (!rtSel_r[3] && srcRise[rtSel_r[2:0]]);

	cdg_tick_div u_rt
	(
		.clock   (clock),
		.nrst    (nrst),
		.inTick  (rtBase),
		.ratio   (rtRatio),
		.enable  (!disable_r[cdg_pkg::DIS_RT]),
		.outTick (realtime_irq_clock)
	);

	////////////////////////////////////////////////////////////////////////
	// reset on slip
	logic rstReq_r;
	logic rstReq_nxt;

	always_comb
	begin
		rstReq_nxt = slipEvt && slipRstEn_r;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rstReq_r <= 1'b0;
		else
			rstReq_r <= rstReq_nxt;
	end

	assign deviceResetReq = rstReq_r;

endmodule

// ==== testbench/cdg_clock_domain_generator_chk.sv ====
`timescale 1ns/10ps
module cdg_clock_domain_generator_chk
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [27:0] addr,
	input wire logic        rdStrobe,
	input wire logic [31:0] rdData,
	input wire logic        pllSlip,
	input wire logic        cpu_logic_selftest,
	input wire logic        systemBusTick,
	input wire logic        cpu_clock,
	input wire logic        cpu_clock_delayed,
	input wire logic        selftestTick,
	input wire logic        periph_clock_primary,
	input wire logic        deviceResetReq,
	input wire logic        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////
	property p_rd_slot;
		rdData != 32'h0 |-> $past(rdStrobe);
	endproperty
	a_rd_slot: assert property (p_rd_slot)
		else $error("read data outside its slot");
	property p_dis_bits;
		rdStrobe && addr == cdg_pkg::OFF_DISABLE |=> rdData[31:10] == 22'h0;
	endproperty
	a_dis_bits: assert property (p_dis_bits)
		else $error("disable register unused bits set");
	property p_bus_pulse;
		systemBusTick |=> !systemBusTick;
	endproperty
	a_bus_pulse: assert property (p_bus_pulse)
		else $error("bus tick longer than one cycle");
	property p_cpu_pulse;
		$rose(cpu_clock) |=> $fell(cpu_clock);
	endproperty
	a_cpu_pulse: assert property (p_cpu_pulse)
		else $error("cpu tick longer than one cycle");
	// sources never edge faster than every third cycle
	property p_dly_gap;
		cpu_clock_delayed |=> !cpu_clock_delayed [*2];
	endproperty
	a_dly_gap: assert property (p_dly_gap)
		else $error("delayed cpu ticks too close");
	// gate is taken at a wrap, so a tick may trail the self-test end
	property p_st_cause;
		selftestTick |-> $past(cpu_clock);
	endproperty
	a_st_cause: assert property (p_st_cause)
		else $error("self-test tick without cpu tick");
	property p_rst_pulse;
		deviceResetReq |=> !deviceResetReq;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("reset request longer than one cycle");
	property p_rst_cause;
		deviceResetReq |-> $past(pllSlip, 2);
	endproperty
	a_rst_cause: assert property (p_rst_cause)
		else $error("reset request without slip");
	property p_irq_clr;
		rdStrobe && addr == cdg_pkg::OFF_STATUS
			&& !($past(pllSlip, 2) && !$past(pllSlip, 3)) |=> !irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr)
		else $error("interrupt stays after status read");
	property p_per_pulse;
		periph_clock_primary |=> !periph_clock_primary;
	endproperty
	a_per_pulse: assert property (p_per_pulse)
		else $error("peripheral tick longer than one cycle");
endmodule

bind cdg_clock_domain_generator cdg_clock_domain_generator_chk
	u_cdg_clock_domain_generator_chk
(
	.clock                (clock),
	.nrst                 (nrst),
	.addr                 (addr),
	.rdStrobe             (rdStrobe),
	.rdData               (rdData),
	.pllSlip              (pllSlip),
	.cpu_logic_selftest   (cpu_logic_selftest),
	.systemBusTick        (systemBusTick),
	.cpu_clock            (cpu_clock),
	.cpu_clock_delayed    (cpu_clock_delayed),
	.selftestTick         (selftestTick),
	.periph_clock_primary (periph_clock_primary),
	.deviceResetReq       (deviceResetReq),
	.irq                  (irq)
);

// ==== testbench/cdg_clock_domain_generator_bench.sv ====
`timescale 1ns/10ps
module cdg_clock_domain_generator_bench;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [27:0] addr = 28'h0;
	logic [31:0] wrData = 32'h0;
	logic        wrStrobe = 1'b0;
	logic        rdStrobe = 1'b0;
	logic [31:0] rdData;
	logic        oscPin = 1'b0;
	logic        pllPin = 1'b0;
	logic        ext1Pin = 1'b0;
	logic        ext2Pin = 1'b0;
	logic        pllSlip = 1'b0;
	logic        selftest = 1'b0;
	wire  [9:0]  outs;
	logic        irq;
	logic        counting = 1'b0;
	int          cnt[10];
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [27:0] regAddr[11] = '{28'hFFFE000, 28'hFFFE004, 28'hFFFE008,
		28'hFFFE00C, 28'hFFFE010, 28'hFFFE014, 28'hFFFE018, 28'hFFFE01C,
		28'hFFFE020, 28'hFFFE108, 28'hFFFE024};
	logic [31:0] regRst[11] = '{32'h0, 32'h9, 32'h9, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h31, 32'h0, 32'h0};

	// pins toggle on falling clock edges to keep clear of sampling
	always #2 clock = ~clock;
	always #16 oscPin = ~oscPin;
	always #12 pllPin = ~pllPin;
	always #20 ext1Pin = ~ext1Pin;
	always #28 ext2Pin = ~ext2Pin;

	cdg_clock_domain_generator u_cdg_clock_domain_generator
	(
		.clock                  (clock),
		.nrst                   (nrst),
		.addr                   (addr),
		.wrData                 (wrData),
		.wrStrobe               (wrStrobe),
		.rdStrobe               (rdStrobe),
		.rdData                 (rdData),
		.main_osc_input         (oscPin),
		.pllClock               (pllPin),
		.external_clock_input1  (ext1Pin),
		.external_clock_input2  (ext2Pin),
		.lfLpoClock             (1'b0),
		.hfLpoClock             (1'b0),
		.pllSlip                (pllSlip),
		.cpu_logic_selftest     (selftest),
		.systemBusTick          (outs[0]),
		.cpu_clock              (outs[1]),
		.cpu_clock_delayed      (outs[2]),
		.selftestTick           (outs[3]),
		.periph_clock_primary   (outs[4]),
		.periph_clock_secondary (outs[5]),
		.periph_clock_fourth    (outs[6]),
		.async_periph_clock     (outs[7]),
		.realtime_irq_clock     (outs[8]),
		.deviceResetReq         (outs[9]),
		.irq                    (irq)
	);
	////////////////////////////////////////////////
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			complete_run();
		end
		for (int i = 0; i < 10; i++)
			if (counting && outs[i] === 1'b1)
				cnt[i]++;
	end

	task automatic fail(input string m);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic wr(input logic [27:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [27:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		@(negedge clock);
		n_checks++;
		if (rdData !== e)
			fail($sformatf("read %h got %h", a, rdData));
	endtask

	task automatic chk_bit(input logic v, input logic e);
		n_checks++;
		if (v !== e)
			fail("flag level");
	endtask

	// settle past the slowest divider wrap, then count one window
	task automatic ticks(input int e[10]);
		repeat (200) @(negedge clock);
		cnt = '{default:0};
		counting = 1'b1;
		repeat (1024) @(negedge clock);
		counting = 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			n_checks++;
			if (cnt[i] > e[i] + 2 || cnt[i] < e[i] - 2
				|| (e[i] == 0 && cnt[i] != 0))
				fail($sformatf("tick count %0d is %0d", i, cnt[i]));
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////
	initial
	begin
		int r;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 11; i++)
			rd(regAddr[i], regRst[i]);
		ticks('{128, 128, 128, 0, 128, 128, 128, 128, 128, 0});
		for (int c = 0; c < 4; c++)
		begin
			wr(28'hFFFE010, 32'(c * 21));
			r = (c == 1) ? 2 : (c == 2) ? 16 : 1;
			ticks('{128, 128, 128, 0, 128 / r, 128 / r, 128 / r,
				128 / r, 128 / r, 0});
		end
		wr(28'hFFFE010, 32'h0);
		wr(28'hFFFE00C, 32'h2);
		ticks('{0, 128, 128, 0, 128, 128, 128, 128, 128, 0});
		wr(28'hFFFE00C, 32'h1);
		ticks('{128, 0, 0, 0, 128, 128, 128, 128, 128, 0});
		wr(28'hFFFE00C, 32'h25C);
		rd(28'hFFFE00C, 32'h25C);
		ticks('{128, 128, 128, 0, 0, 0, 0, 0, 0, 0});
		wr(28'hFFFE00C, 32'h0);
		selftest <= 1'b1;
		for (int d = 0; d < 8; d = d * 2 + 1)
		begin
			wr(28'hFFFE108, 32'(d));
			ticks('{128, 128 / (d + 1), 128 / (d + 1), 64 / (d + 1), 128,
				128, 128, 128, 128, 0});
		end
		selftest <= 1'b0;
		ticks('{128, 128, 128, 0, 128, 128, 128, 128, 128, 0});
		wr(28'hFFFE008, 32'h309);
		wr(28'hFFFE004, 32'h1);
		ticks('{128, 128, 128, 0, 128, 128, 128, 0, 16, 0});
		wr(28'hFFFE020, 32'h39);
		wr(28'hFFFE004, 32'h3);
		// realtime on external 1 divided by 8 stays below a third
		wr(28'hFFFE008, 32'h303);
		ticks('{128, 128, 128, 0, 128, 128, 128, 102, 13, 0});
		wr(28'hFFFE004, 32'h9);
		wr(28'hFFFE008, 32'h9);
		wr(28'hFFFE01C, 32'h3);
		wr(28'hFFFE000, 32'h3);
		repeat (40) @(posedge clock);
		chk_bit(irq, 1'b1);
		rd(28'hFFFE018, 32'h2);
		chk_bit(irq, 1'b0);
		ticks('{102, 102, 102, 0, 102, 102, 102, 102, 102, 0});
		wr(28'hFFFE01C, 32'h1);
		wr(28'hFFFE000, 32'h0);
		repeat (40) @(posedge clock);
		chk_bit(irq, 1'b0);
		rd(28'hFFFE018, 32'h2);
		for (int s = 1; s >= 0; s--)
		begin
			wr(28'hFFFE014, 32'(s));
			@(negedge clock);
			cnt = '{default:0};
			counting = 1'b1;
			@(posedge clock);
			pllSlip <= 1'b1;
			repeat (20) @(posedge clock);
			pllSlip <= 1'b0;
			repeat (10) @(negedge clock);
			counting = 1'b0;
			chk_bit(cnt[9] == s, 1'b1);
			chk_bit(irq, 1'b1);
			rd(28'hFFFE018, 32'h1);
		end
		complete_run();
	end
endmodule
